// ==== hw/pef_alt_override_top.sv ====
/*
 * Alternate-function override for port E bits 3:0 and port F bits 7:0,
 * with port registers on APB and a small test-access port on port F.
 * Assumes pin and peripheral inputs are synchronous to CLOCK and TCK is
 * much slower than CLOCK, so it is sampled as an ordinary input.
 */
// The APB slave port and the register offsets were left to the implementer.
// Behaviour
// - Sync clock pin direction follows bit 2
// - Clock override only in synchronous mode
// - Receiver forces bit 0 input, latch pull-up
// - Transmitter drives bit 1, pull-up off
// - Pin-change source 8 forces input enable
// - Programming uses bit 1 out, bit 0 in
// - TCK, TMS and TDI keep pull-ups, even in reset; TDO has none
// - TDI shifts into selected scan chain
// - TDO driven only in shift states
// - TMS sampled to step the TAP
// - TAP steps only on TCK rising edges
// - Test port claims port F bits 7:4
// - Port F bits 3:0 never overridden
`timescale 1ns/100ps
module pef_alt_override_top (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Port E pins 3:0
	input wire logic [pef_pkg::NUM_E-1:0] PE_IN,
	output logic [pef_pkg::NUM_E-1:0] PE_OUT,
	output logic [pef_pkg::NUM_E-1:0] PE_OE,
	output logic [pef_pkg::NUM_E-1:0] PE_PULLUP,
	output logic [pef_pkg::NUM_E-1:0] PE_IN_EN,
	// Port F pins 7:0
	input wire logic [pef_pkg::NUM_F-1:0] PF_IN,
	output logic [pef_pkg::NUM_F-1:0] PF_OUT,
	output logic [pef_pkg::NUM_F-1:0] PF_OE,
	output logic [pef_pkg::NUM_F-1:0] PF_PULLUP,
	output logic [pef_pkg::NUM_F-1:0] PF_IN_EN,
	// USART0
	input wire logic USART0_RECEIVER_ENABLE,
	input wire logic USART0_TRANSMITTER_ENABLE,
	input wire logic USART0_TX_DATA,
	input wire logic USART0_SYNC_MODE,
	input wire logic USART0_CLOCK_OUT,
	output logic USART0_RX_DATA,
	output logic USART0_CLOCK_IN,
	// Serial programming
	input wire logic SERIAL_PROG_ACTIVE,
	input wire logic SERIAL_PROG_DATA_OUT,
	output logic SERIAL_PROG_DATA_IN,
	// Pin change and test port
	output logic PIN_CHANGE_SOURCE_8,
	input wire logic TEST_PORT_ENABLE_FUSE
);
	import pef_pkg::*;

	// Port and control registers
	logic [NUM_E-1:0] latch_e_reg, dir_e_reg;
	logic [NUM_F-1:0] latch_f_reg, dir_f_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [NUM_PIN-1:0] in_dis_reg;
	// Bus answer
	logic [31:0] prdata_reg, rd_value;
	logic pslverr_reg, rd_err;
	logic apb_wr, apb_setup;
	// TAP state
	pef_tap_t tap_state_reg, tap_next;
	logic tck_prev_reg, tck_rise, tck_fall;
	logic [IR_W-1:0] ir_shift_reg, ir_reg;
	logic bypass_reg, tdo_reg;
	logic shifting, jtag;
	// Registered pin controls
	logic [NUM_PIN-1:0] pu_reg, oe_reg, out_reg, die_reg;
	// Registered peripheral inputs
	logic rx_reg, xck_in_reg, prog_in_reg, pc8_reg;
	// Named pin samples
	logic tck, tms, tdi;

	pef_ovr_if ovr_bus ();

	assign jtag = TEST_PORT_ENABLE_FUSE;
	assign tck = PF_IN[F_TCK_BIT];
	assign tms = PF_IN[F_TMS_BIT];
	assign tdi = PF_IN[F_TDI_BIT];

	// Bus phases; zero wait states
	assign apb_setup = PSEL & ~PENABLE;
	assign apb_wr = PSEL & PENABLE & PWRITE;
	assign PREADY = 1'b1;
	assign PRDATA = prdata_reg;
	assign PSLVERR = pslverr_reg;

	// Software-written port settings
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			latch_e_reg <= RST_LATCH_E;
			dir_e_reg <= RST_DIR_E;
			latch_f_reg <= RST_LATCH_F;
			dir_f_reg <= RST_DIR_F;
			ctrl_reg <= RST_CTRL;
			in_dis_reg <= RST_IN_DIS;
		end else if (apb_wr) begin
			case (PADDR)
				OFF_LATCH_E: latch_e_reg <= PWDATA[NUM_E-1:0];
				OFF_DIR_E: dir_e_reg <= PWDATA[NUM_E-1:0];
				OFF_LATCH_F: latch_f_reg <= PWDATA[NUM_F-1:0];
				OFF_DIR_F: dir_f_reg <= PWDATA[NUM_F-1:0];
				OFF_CTRL: ctrl_reg <= PWDATA[CTRL_W-1:0];
				OFF_IN_DIS: in_dis_reg <= PWDATA[NUM_PIN-1:0];
				// Status and unmapped writes are dropped
				default: ;
			endcase
		end
	end

	// Read decode; unmapped offsets answer zero with an error
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_err = 1'b0;
		case (PADDR)
			OFF_LATCH_E: rd_value = 32'(latch_e_reg);
			OFF_DIR_E: rd_value = 32'(dir_e_reg);
			OFF_LATCH_F: rd_value = 32'(latch_f_reg);
			OFF_DIR_F: rd_value = 32'(dir_f_reg);
			OFF_CTRL: rd_value = 32'(ctrl_reg);
			OFF_IN_DIS: rd_value = 32'(in_dis_reg);
			OFF_PIN_STAT: rd_value = 32'({PF_IN, PE_IN});
			OFF_TAP_STAT: rd_value = 32'({ir_reg, tap_state_reg});
			default: rd_err = 1'b1;
		endcase
	end

	// Answer captured in setup so access data comes from a flop
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (apb_setup) begin
			prdata_reg <= PWRITE ? 32'h0000_0000 : rd_value;
			pslverr_reg <= rd_err;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			tck_prev_reg <= 1'b0;
		end else begin
			tck_prev_reg <= tck;
		end
	end
	assign tck_rise = tck & ~tck_prev_reg;
	assign tck_fall = ~tck & tck_prev_reg;

	always_comb begin
		tap_next = tap_state_reg;
		case (tap_state_reg)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_DATA_REG_SHIFT_STATE;
			TAP_DATA_REG_SHIFT_STATE: tap_next = tms ? TAP_EXIT1_DR : TAP_DATA_REG_SHIFT_STATE;
			TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_DATA_REG_SHIFT_STATE;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_INSTR_REG_SHIFT_STATE;
			TAP_INSTR_REG_SHIFT_STATE: tap_next = tms ? TAP_EXIT1_IR : TAP_INSTR_REG_SHIFT_STATE;
			TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_INSTR_REG_SHIFT_STATE;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			tap_state_reg <= TAP_RESET;
		end else if (!jtag) begin
			// Fuse off parks the controller
			tap_state_reg <= TAP_RESET;
		end else if (tck_rise) begin
			tap_state_reg <= tap_next;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			ir_shift_reg <= IR_CAPTURE;
			ir_reg <= IR_BYPASS;
		end else if (tap_state_reg == TAP_RESET) begin
			ir_reg <= IR_BYPASS;
		end else if (tck_rise) begin
			case (tap_state_reg)
				TAP_CAP_IR: ir_shift_reg <= IR_CAPTURE;
				TAP_INSTR_REG_SHIFT_STATE: ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
				TAP_UPD_IR: ir_reg <= ir_shift_reg;
				default: ;
			endcase
		end
	end

	// data chain shift; every instruction selects the bypass bit
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			bypass_reg <= 1'b0;
		end else if (tck_rise) begin
			case (tap_state_reg)
				TAP_CAP_DR: bypass_reg <= 1'b0;
				TAP_DATA_REG_SHIFT_STATE: bypass_reg <= tdi;
				default: ;
			endcase
		end
	end

	// Test data out changes on TCK fall, as the tester samples on rise
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			tdo_reg <= 1'b0;
		end else if (tck_fall) begin
			if (tap_state_reg == TAP_INSTR_REG_SHIFT_STATE) begin
				tdo_reg <= ir_shift_reg[0];
			end else if (tap_state_reg == TAP_DATA_REG_SHIFT_STATE) begin
				tdo_reg <= bypass_reg;
			end
		end
	end

	assign shifting = (tap_state_reg == TAP_INSTR_REG_SHIFT_STATE) ||
		(tap_state_reg == TAP_DATA_REG_SHIFT_STATE);

	// Port settings into the bundle
	always_comb begin
		ovr_bus.latch = {latch_f_reg, latch_e_reg};
		ovr_bus.dir = {dir_f_reg, dir_e_reg};
		ovr_bus.in_dis = in_dis_reg;
		ovr_bus.global_pullup_disable = ctrl_reg[CTRL_GLOBAL_PULLUP_DISABLE_BIT];
	end

	// Peripheral overrides; unlisted pins carry zero overrides
	always_comb begin
		ovr_bus.pullup_override_enable = 12'h000;
		ovr_bus.pullup_override_value = 12'h000;
		ovr_bus.direction_override_enable = 12'h000;
		ovr_bus.direction_override_value = 12'h000;
		ovr_bus.output_value_override_enable = 12'h000;
		ovr_bus.output_value_override_value = 12'h000;
		ovr_bus.input_enable_override_enable = 12'h000;
		ovr_bus.input_enable_override_value = 12'h000;
		if (USART0_SYNC_MODE && dir_e_reg[E_XCK_BIT]) begin
			ovr_bus.direction_override_enable[E_BASE+E_XCK_BIT] = 1'b1;
			ovr_bus.direction_override_value[E_BASE+E_XCK_BIT] = 1'b1;
			ovr_bus.output_value_override_enable[E_BASE+E_XCK_BIT] = 1'b1;
			ovr_bus.output_value_override_value[E_BASE+E_XCK_BIT] =
				USART0_CLOCK_OUT;
		end
		// programming lines win over the USART
		if (SERIAL_PROG_ACTIVE) begin
			ovr_bus.pullup_override_enable[E_BASE+E_TX_BIT] = 1'b1;
			ovr_bus.direction_override_enable[E_BASE+E_TX_BIT] = 1'b1;
			ovr_bus.direction_override_value[E_BASE+E_TX_BIT] = 1'b1;
			ovr_bus.output_value_override_enable[E_BASE+E_TX_BIT] = 1'b1;
			ovr_bus.output_value_override_value[E_BASE+E_TX_BIT] =
				SERIAL_PROG_DATA_OUT;
			ovr_bus.direction_override_enable[E_BASE+E_RX_BIT] = 1'b1;
		end else begin
			if (USART0_TRANSMITTER_ENABLE) begin
				ovr_bus.pullup_override_enable[E_BASE+E_TX_BIT] = 1'b1;
				ovr_bus.direction_override_enable[E_BASE+E_TX_BIT] = 1'b1;
				ovr_bus.direction_override_value[E_BASE+E_TX_BIT] = 1'b1;
				ovr_bus.output_value_override_enable[E_BASE+E_TX_BIT] = 1'b1;
				ovr_bus.output_value_override_value[E_BASE+E_TX_BIT] =
					USART0_TX_DATA;
			end
			if (USART0_RECEIVER_ENABLE) begin
				ovr_bus.pullup_override_enable[E_BASE+E_RX_BIT] = 1'b1;
				ovr_bus.pullup_override_value[E_BASE+E_RX_BIT] =
					latch_e_reg[E_RX_BIT] &
					~ctrl_reg[CTRL_GLOBAL_PULLUP_DISABLE_BIT];
				ovr_bus.direction_override_enable[E_BASE+E_RX_BIT] = 1'b1;
			end
		end
		if (ctrl_reg[CTRL_PCMSK8_BIT] &&
			ctrl_reg[CTRL_PIN_CHANGE_GROUP1_ENABLE_BIT]) begin
			ovr_bus.input_enable_override_enable[E_BASE+E_RX_BIT] = 1'b1;
			ovr_bus.input_enable_override_value[E_BASE+E_RX_BIT] = 1'b1;
		end
		if (jtag) begin
			ovr_bus.pullup_override_enable[F_BASE+7:F_BASE+4] = 4'hF;
			ovr_bus.pullup_override_value[F_BASE+7:F_BASE+4] =
				F_JTAG_PU_MASK[7:4];
			ovr_bus.direction_override_enable[F_BASE+7:F_BASE+4] = 4'hF;
			ovr_bus.input_enable_override_enable[F_BASE+7:F_BASE+4] = 4'hF;
			ovr_bus.direction_override_value[F_BASE+F_TDO_BIT] = shifting;
			ovr_bus.output_value_override_enable[F_BASE+F_TDO_BIT] = 1'b1;
			ovr_bus.output_value_override_value[F_BASE+F_TDO_BIT] = tdo_reg;
		end
		// bits 3:0 of port F stay untouched above
	end

	// One resolver per pin
	for (genvar g = 0; g < NUM_PIN; g++) begin : g_pin
		pef_pin_mux #(.IDX(g)) u_mux (.ovr(ovr_bus));
	end

	// Resolved controls into output flops
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			pu_reg <= 12'h000;
			oe_reg <= 12'h000;
			out_reg <= 12'h000;
			die_reg <= 12'h000;
		end else begin
			pu_reg <= ovr_bus.res_pu;
			oe_reg <= ovr_bus.res_oe;
			out_reg <= ovr_bus.res_out;
			die_reg <= ovr_bus.res_die;
		end
	end

	// Peripheral-side input samples
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			rx_reg <= 1'b0;
			xck_in_reg <= 1'b0;
			prog_in_reg <= 1'b0;
			pc8_reg <= 1'b0;
		end else begin
			rx_reg <= PE_IN[E_RX_BIT];
			xck_in_reg <= PE_IN[E_XCK_BIT];
			prog_in_reg <= PE_IN[E_RX_BIT];
			pc8_reg <= PE_IN[E_RX_BIT] & die_reg[E_BASE+E_RX_BIT];
		end
	end

	assign PE_OUT = out_reg[E_BASE+NUM_E-1:E_BASE];
	assign PE_OE = oe_reg[E_BASE+NUM_E-1:E_BASE];
	assign PE_PULLUP = pu_reg[E_BASE+NUM_E-1:E_BASE];
	assign PE_IN_EN = die_reg[E_BASE+NUM_E-1:E_BASE];
	assign PF_OUT = out_reg[F_BASE+NUM_F-1:F_BASE];
	assign PF_OE = oe_reg[F_BASE+NUM_F-1:F_BASE];
	assign PF_PULLUP = pu_reg[F_BASE+NUM_F-1:F_BASE] |
		(jtag ? F_JTAG_PU_MASK : 8'h00);
	assign PF_IN_EN = die_reg[F_BASE+NUM_F-1:F_BASE];
	assign USART0_RX_DATA = rx_reg;
	assign USART0_CLOCK_IN = xck_in_reg;
	assign SERIAL_PROG_DATA_IN = prog_in_reg;
	assign PIN_CHANGE_SOURCE_8 = pc8_reg;

	// Checks on pin controls and TAP behaviour
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	AST_XCK_OUT: assert property (USART0_SYNC_MODE && dir_e_reg[2] &&
		!SERIAL_PROG_ACTIVE |=> PE_OE[2] && PE_OUT[2] == $past(USART0_CLOCK_OUT))
		else $error("sync clock pin not driven");
	AST_XCK_ASYNC: assert property (!USART0_SYNC_MODE |=>
		PE_OE[2] == $past(dir_e_reg[2]) && PE_OUT[2] == $past(latch_e_reg[2]))
		else $error("clock pin overridden in async mode");
	AST_RX_PIN: assert property (USART0_RECEIVER_ENABLE &&
		!SERIAL_PROG_ACTIVE |=> !PE_OE[0] &&
		PE_PULLUP[0] == $past(latch_e_reg[0] & ~ctrl_reg[0]))
		else $error("receive pin not forced input");
	AST_TX_PIN: assert property (USART0_TRANSMITTER_ENABLE &&
		!SERIAL_PROG_ACTIVE |=> PE_OE[1] && !PE_PULLUP[1] &&
		PE_OUT[1] == $past(USART0_TX_DATA))
		else $error("transmit pin not driven");
	AST_PC8_DIE: assert property (ctrl_reg[1] && ctrl_reg[2] |=>
		PE_IN_EN[0]) else $error("pin-change input disabled");
	AST_PROG_LINES: assert property (SERIAL_PROG_ACTIVE |=>
		PE_OE[1] && !PE_OE[0] && PE_OUT[1] == $past(SERIAL_PROG_DATA_OUT))
		else $error("programming lines wrong");
	AST_JTAG_PU: assert property (disable iff (1'b0) jtag |->
		PF_PULLUP[7] && PF_PULLUP[5] && PF_PULLUP[4])
		else $error("test pin pull-up missing");
	AST_BYPASS_SHIFT: assert property (jtag && tck_rise &&
		tap_state_reg == TAP_DATA_REG_SHIFT_STATE |=> bypass_reg == $past(tdi))
		else $error("bypass bit did not shift");
	AST_TDO_TRI: assert property (jtag && !shifting |=> !PF_OE[6])
		else $error("TDO driven outside shift");
	AST_TMS_STEP: assert property (jtag && tck_rise &&
		tap_state_reg == TAP_DATA_REG_SHIFT_STATE && tms |=> tap_state_reg == TAP_EXIT1_DR)
		else $error("TMS did not leave shift");
	AST_TAP_HOLD: assert property (jtag && !tck_rise |=>
		tap_state_reg == $past(tap_state_reg))
		else $error("TAP moved without TCK");
	AST_JTAG_PINS: assert property (jtag |=> PF_IN_EN[7:4] == 4'h0 &&
		!PF_OE[7] && !PF_OE[5] && !PF_OE[4])
		else $error("test pins not claimed");
	AST_F_LOW: assert property (1'b1 |=>
		PF_OE[3:0] == $past(dir_f_reg[3:0]) && PF_OUT[3:0] ==
		$past(latch_f_reg[3:0])) else $error("port F low overridden");

	COV_TX: cover property (USART0_TRANSMITTER_ENABLE ##1 PE_OE[1]);
	COV_DATA_REG_SHIFT_STATE: cover property (tap_state_reg == TAP_DATA_REG_SHIFT_STATE ##1 PF_OE[6]);
	COV_APB_WR: cover property (apb_wr && PADDR == OFF_DIR_F);
endmodule // pef_alt_override_top

// ==== hw/pef_ovr_if.sv ====
/*
 * Override bundle between the control logic and the per-pin resolvers.
 * Assumes bit i of every vector belongs to pin i of the combined vector.
 */
`timescale 1ns/100ps
interface pef_ovr_if;
	// Overrides from peripherals
	logic [11:0] pullup_override_enable, pullup_override_value;
	logic [11:0] direction_override_enable, direction_override_value;
	logic [11:0] output_value_override_enable, output_value_override_value;
	logic [11:0] input_enable_override_enable, input_enable_override_value;
	// Port register settings
	logic [11:0] latch, dir, in_dis;
	logic global_pullup_disable;
	// Resolved pin controls, one bit per resolver
	wire [11:0] res_pu, res_oe, res_out, res_die;

	modport ctl (
		output pullup_override_enable, pullup_override_value,
		output direction_override_enable, direction_override_value,
		output output_value_override_enable, output_value_override_value,
		output input_enable_override_enable, input_enable_override_value,
		output latch, dir, in_dis, global_pullup_disable,
		input res_pu, res_oe, res_out, res_die);
	modport pin (
		input pullup_override_enable, pullup_override_value,
		input direction_override_enable, direction_override_value,
		input output_value_override_enable, output_value_override_value,
		input input_enable_override_enable, input_enable_override_value,
		input latch, dir, in_dis, global_pullup_disable,
		output res_pu, res_oe, res_out, res_die);
endinterface // pef_ovr_if

// ==== hw/pef_pin_mux.sv ====
/*
 * One pin's override resolver: picks override value or port setting.
 * Assumes the bundle is driven by the control logic each cycle.
 */
`timescale 1ns/100ps
module pef_pin_mux #(
	parameter int IDX = 0
) (
	// Override bundle
	pef_ovr_if.pin ovr
);
	// Plain port pull-up: latch high on an input, not globally disabled
	logic base_pu;
	assign base_pu = ovr.latch[IDX] & ~ovr.dir[IDX] &
		~ovr.global_pullup_disable;

	assign ovr.res_pu[IDX] = ovr.pullup_override_enable[IDX] ?
		ovr.pullup_override_value[IDX] : base_pu;
	assign ovr.res_oe[IDX] = ovr.direction_override_enable[IDX] ?
		ovr.direction_override_value[IDX] : ovr.dir[IDX];
	assign ovr.res_out[IDX] = ovr.output_value_override_enable[IDX] ?
		ovr.output_value_override_value[IDX] : ovr.latch[IDX];
	// Input buffer follows its override, else stays on unless software disabled it
	assign ovr.res_die[IDX] = ovr.input_enable_override_enable[IDX] ?
		ovr.input_enable_override_value[IDX] : ~ovr.in_dis[IDX];
endmodule // pef_pin_mux

// ==== hw/pef_pkg.sv ====
/*
 * Constants, offsets, field positions and the TAP state type for the
 * port E/F alternate-function override block.
 * Assumes a 32-bit APB register bus with byte addresses in PADDR.
 */
package pef_pkg;

	// Pin counts and positions in the combined pin vector
	localparam int NUM_E = 4;
	localparam int NUM_F = 8;
	localparam int NUM_PIN = 12;
	localparam int E_BASE = 0;
	localparam int F_BASE = 4;

	// Port E low-nibble pin roles
	localparam int E_RX_BIT = 0;
	localparam int E_TX_BIT = 1;
	localparam int E_XCK_BIT = 2;

	// Port F test-port pin roles
	localparam int F_TCK_BIT = 4;
	localparam int F_TMS_BIT = 5;
	localparam int F_TDO_BIT = 6;
	localparam int F_TDI_BIT = 7;
	localparam logic [7:0] F_JTAG_MASK = 8'hF0;
	localparam logic [7:0] F_JTAG_PU_MASK = 8'hB0;

	// Register byte offsets
	localparam logic [7:0] OFF_LATCH_E = 8'h00;
	localparam logic [7:0] OFF_DIR_E = 8'h04;
	localparam logic [7:0] OFF_LATCH_F = 8'h08;
	localparam logic [7:0] OFF_DIR_F = 8'h0C;
	localparam logic [7:0] OFF_CTRL = 8'h10;
	localparam logic [7:0] OFF_IN_DIS = 8'h14;
	localparam logic [7:0] OFF_PIN_STAT = 8'h18;
	localparam logic [7:0] OFF_TAP_STAT = 8'h1C;

	// Control register fields
	localparam int CTRL_GLOBAL_PULLUP_DISABLE_BIT = 0;
	localparam int CTRL_PIN_CHANGE_GROUP1_ENABLE_BIT = 1;
	localparam int CTRL_PCMSK8_BIT = 2;
	localparam int CTRL_W = 3;

	// Reset values
	localparam logic [3:0] RST_LATCH_E = 4'h0;
	localparam logic [3:0] RST_DIR_E = 4'h0;
	localparam logic [7:0] RST_LATCH_F = 8'h00;
	localparam logic [7:0] RST_DIR_F = 8'h00;
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [11:0] RST_IN_DIS = 12'h000;

	// Instruction register
	localparam int IR_W = 4;
	localparam logic [3:0] IR_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// TAP controller states
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_DATA_REG_SHIFT_STATE,
		TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_INSTR_REG_SHIFT_STATE, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} pef_tap_t;

endpackage

// ==== tb/pef_alt_override_top_tb.sv ====
/* Self-checking bench for the port E/F override block.
 * Assumes the pad model closes the pin loop; APB answers in one access. */
`timescale 1ns/100ps
module pef_alt_override_top_tb;
	import pef_pkg::*;
	// Bench signals
	logic clock, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pe_in, pe_out, pe_oe, pe_pu, pe_ien, e_ext;
	logic [7:0] pf_in, pf_out, pf_oe, pf_pu, pf_ien, f_ext;
	logic rx_en, tx_en, tx_d, sync, ck_out, rx_d, ck_in;
	logic sp_act, sp_out, sp_in, pc8, fuse;
	int miscompares, total_checks;
	pef_alt_override_top i_pef_alt_override_top (
		.CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PE_IN(pe_in), .PE_OUT(pe_out), .PE_OE(pe_oe),
		.PE_PULLUP(pe_pu), .PE_IN_EN(pe_ien), .PF_IN(pf_in),
		.PF_OUT(pf_out), .PF_OE(pf_oe), .PF_PULLUP(pf_pu),
		.PF_IN_EN(pf_ien), .USART0_RECEIVER_ENABLE(rx_en),
		.USART0_TRANSMITTER_ENABLE(tx_en), .USART0_TX_DATA(tx_d),
		.USART0_SYNC_MODE(sync), .USART0_CLOCK_OUT(ck_out),
		.USART0_RX_DATA(rx_d), .USART0_CLOCK_IN(ck_in),
		.SERIAL_PROG_ACTIVE(sp_act), .SERIAL_PROG_DATA_OUT(sp_out),
		.SERIAL_PROG_DATA_IN(sp_in), .PIN_CHANGE_SOURCE_8(pc8),
		.TEST_PORT_ENABLE_FUSE(fuse));
	pef_pad_model i_pef_pad_model (
		.clk(clock), .e_out(pe_out), .e_oe(pe_oe), .f_out(pf_out),
		.f_oe(pf_oe), .f_pu(pf_pu), .e_ext(e_ext), .f_ext(f_ext),
		.f_ext_en(8'hB0), .e_in(pe_in), .f_in(pf_in));
	// Clock, 5 ns period
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Case-equal compare with report
	task chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; waits for PREADY
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees PREADY
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// Tester clocks the TAP, TMS and TDI set while TCK is low
	task tck_cyc(input logic tms, input logic tdi);
		@(posedge clock);
		f_ext <= {tdi, 1'b0, tms, 1'b0, 4'h0};
		tick(4);
		f_ext <= {tdi, 1'b0, tms, 1'b1, 4'h0};
		tick(4);
	endtask
	task test_end(input string nm);
		$display("test %s finished", nm);
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Watchdog, far beyond the expected run
	initial begin
		tick(20000);
		miscompares++;
		finish_test();
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_en, tx_en, tx_d, sync, ck_out, sp_act, sp_out} = '0;
		e_ext = 4'h0;
		f_ext = 8'h00;
		fuse = 1'b1;
		reset = 1'b1;
		miscompares = 0;
		total_checks = 0;
		tick(2);
		chk("pf_pu_rst", 32'hB0, 32'(pf_pu));
		tick(6);
		reset <= 1'b0;
		test_end("reset");
		apb(1'b1, OFF_LATCH_E, 32'h3);
		apb(1'b1, OFF_DIR_E, 32'h4);
		// Port F outputs set once, never toggled later
		apb(1'b1, OFF_LATCH_F, 32'hA5);
		apb(1'b1, OFF_DIR_F, 32'hFF);
		rchk("latch_e", OFF_LATCH_E, 32'h3);
		rchk("dir_f", OFF_DIR_F, 32'hFF);
		rchk("ctrl", OFF_CTRL, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, 32'(err));
		chk("pe_oe", 32'h4, 32'(pe_oe));
		chk("pe_out", 32'h3, 32'(pe_out));
		chk("pe_pu", 32'h3, 32'(pe_pu));
		test_end("registers");
		@(posedge clock);
		tx_en <= 1'b1;
		tick(3);
		chk("tx_oe", 32'h6, 32'(pe_oe));
		chk("tx_out", 32'h1, 32'(pe_out));
		chk("tx_pu", 32'h1, 32'(pe_pu));
		tx_d <= 1'b1;
		tick(3);
		chk("tx_out1", 32'h3, 32'(pe_out));
		tx_en <= 1'b0;
		rx_en <= 1'b1;
		e_ext <= 4'h1;
		apb(1'b1, OFF_DIR_E, 32'h5);
		tick(3);
		chk("rx_oe", 32'h4, 32'(pe_oe));
		chk("rx_pu", 32'h3, 32'(pe_pu));
		chk("rx_data", 32'h1, 32'(rx_d));
		apb(1'b1, OFF_CTRL, 32'h1);
		tick(3);
		chk("rx_pud", 32'h0, 32'(pe_pu));
		apb(1'b1, OFF_CTRL, 32'h0);
		ck_out <= 1'b1;
		tick(3);
		chk("async_out", 32'h3, 32'(pe_out));
		sync <= 1'b1;
		tick(3);
		chk("sync_out", 32'h7, 32'(pe_out));
		apb(1'b1, OFF_DIR_E, 32'h1);
		e_ext <= 4'h4;
		tick(3);
		chk("sync_oe", 32'h0, 32'(pe_oe));
		chk("sync_in", 32'h1, 32'(ck_in));
		test_end("usart");
		apb(1'b1, OFF_IN_DIS, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h6);
		e_ext <= 4'h5;
		tick(3);
		chk("pc_ien", 32'hF, 32'(pe_ien));
		chk("pc_src", 32'h1, 32'(pc8));
		apb(1'b1, OFF_CTRL, 32'h2);
		tick(3);
		chk("pc_ien_off", 32'hE, 32'(pe_ien));
		sp_act <= 1'b1;
		tx_en <= 1'b1;
		tick(3);
		chk("prog_out", 32'h0, 32'(pe_out[1]));
		chk("prog_oe", 32'h2, 32'(pe_oe[1:0]));
		chk("prog_in", 32'h1, 32'(sp_in));
		sp_out <= 1'b1;
		tick(3);
		chk("prog_out1", 32'h1, 32'(pe_out[1]));
		test_end("pin_change_prog");
		chk("jt_oe", 32'h0F, 32'(pf_oe));
		chk("jt_out", 32'hA5, 32'(pf_out));
		chk("jt_pu", 32'hB0, 32'(pf_pu));
		chk("jt_ien", 32'h0F, 32'(pf_ien));
		tck_cyc(1'b0, 1'b0);
		rchk("tap_idle", OFF_TAP_STAT, 32'hF1);
		tck_cyc(1'b1, 1'b0);
		tck_cyc(1'b0, 1'b0);
		tck_cyc(1'b0, 1'b0);
		rchk("tap_shift", OFF_TAP_STAT, 32'hF4);
		chk("tdo_oe", 32'h1, 32'(pf_oe[6]));
		repeat (3) tck_cyc(1'b0, 1'b1);
		chk("tdo_one", 32'h1, 32'(pf_out[6]));
		repeat (2) tck_cyc(1'b0, 1'b0);
		chk("tdo_zero", 32'h0, 32'(pf_out[6]));
		tck_cyc(1'b1, 1'b0);
		rchk("tap_exit", OFF_TAP_STAT, 32'hF5);
		chk("tdo_off", 32'h0F, 32'(pf_oe));
		// Instruction scan: capture 0001 out, 0110 in, LSB first
		repeat (3) tck_cyc(1'b1, 1'b0);
		repeat (2) tck_cyc(1'b0, 1'b0);
		chk("ir_oe", 32'h1, 32'(pf_oe[6]));
		tck_cyc(1'b0, 1'b0);
		chk("ir_tdo1", 32'h1, 32'(pf_out[6]));
		tck_cyc(1'b0, 1'b1);
		chk("ir_tdo0", 32'h0, 32'(pf_out[6]));
		tck_cyc(1'b0, 1'b1);
		repeat (2) tck_cyc(1'b1, 1'b0);
		tck_cyc(1'b0, 1'b0);
		rchk("tap_ir", OFF_TAP_STAT, 32'h61);
		test_end("test_port");
		@(posedge clock);
		fuse <= 1'b0;
		tick(3);
		chk("f_oe", 32'hFF, 32'(pf_oe));
		chk("f_out", 32'hA5, 32'(pf_out));
		chk("f_pu", 32'h00, 32'(pf_pu));
		chk("f_ien", 32'hFF, 32'(pf_ien));
		rchk("pin_stat", OFF_PIN_STAT, 32'hA57);
		test_end("fuse_off");
		finish_test();
	end
endmodule // pef_alt_override_top_tb

// ==== tb/pef_pad_model.sv ====
/* Pad model for port E and port F pins.
 * Assumes the bench gives external levels; design drive wins. */
`timescale 1ns/100ps
module pef_pad_model (
	// Clock
	input wire logic clk,
	// Design pin drive
	input wire logic [3:0] e_out,
	input wire logic [3:0] e_oe,
	input wire logic [7:0] f_out,
	input wire logic [7:0] f_oe,
	input wire logic [7:0] f_pu,
	// External drivers
	input wire logic [3:0] e_ext,
	input wire logic [7:0] f_ext,
	input wire logic [7:0] f_ext_en,
	// Pin levels seen by the design
	output logic [3:0] e_in,
	output logic [7:0] f_in
);
	// Floating pins must not keep a stale level
	logic flt_reg = 1'b0;
	always_ff @(posedge clk) begin
		flt_reg <= ~flt_reg;
	end
	// Port E is always driven by someone
	assign e_in = (e_oe & e_out) | (~e_oe & e_ext);
	// Design, then tester, then pull-up, else float
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (f_oe[i]) f_in[i] = f_out[i];
			else if (f_ext_en[i]) f_in[i] = f_ext[i];
			else if (f_pu[i]) f_in[i] = 1'b1;
			else f_in[i] = flt_reg;
		end
	end
endmodule // pef_pad_model
